/* hw/wkd_map.svh */
// constant map for the wake input detector
// assumes a 100 MHz core clock; included by wkd_pkg users
`ifndef WKD_MAP_SVH
`define WKD_MAP_SVH
`define WKD_CLK_MHZ 100
`define WKD_SHORT_FILTER_US 16
`define WKD_LONG_FILTER_US 64
`define WKD_SHORT_FILTER_CYC (`WKD_SHORT_FILTER_US * `WKD_CLK_MHZ)
`define WKD_LONG_FILTER_CYC (`WKD_LONG_FILTER_US * `WKD_CLK_MHZ)
`define WKD_CNT_W 13
`define WKD_NUM_WAKE 3
`define WKD_NUM_ALT 2
`define WKD_BIAS_NONE 2'h0
`define WKD_BIAS_DOWN 2'h1
`define WKD_BIAS_UP 2'h2
`define WKD_BIAS_AUTO 2'h3
`define WKD_DET_STATIC_SHORT 2'h0
`define WKD_DET_STATIC_LONG 2'h1
`define WKD_DET_CYCLIC_A 2'h2
`define WKD_DET_CYCLIC_B 2'h3
`endif

/* hw/wkd_pkg.sv */
// types for the wake input detector
// assumes wkd_map.svh supplies the numeric constants
package wkd_pkg;
    typedef enum logic [1:0] {
        WKD_NORMAL,
        WKD_STOP,
        WKD_SLEEP,
        WKD_FAILSAFE
    } wkd_mode_type;

    typedef struct packed {
        logic [1:0] bias_sel;
        logic [1:0] detect_sel;
        logic wake_en;
    } wkd_pin_cfg_type;

    typedef struct packed {
        logic pull_up_en;
        logic pull_down_en;
    } wkd_bias_type;
endpackage : wkd_pkg

/* hw/wkd_filter.sv */
// one glitch filter with both-edge detection
// assumes a synchronised input on core_clk
`timescale 1ns/1ps
`include "wkd_map.svh"
module wkd_filter (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic sample_in,
    input wire logic active,
    input wire logic long_sel,
    output logic level_out,
    output logic edge_out
);
    logic level_r;
    logic edge_r;
    logic [`WKD_CNT_W-1:0] cnt_r;
    logic [`WKD_CNT_W-1:0] limit;

    assign limit = long_sel ? `WKD_CNT_W'(`WKD_LONG_FILTER_CYC - 1)
                            : `WKD_CNT_W'(`WKD_SHORT_FILTER_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // counter restarts whenever the input returns to the accepted level
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            level_r <= 1'b0;
            edge_r <= 1'b0;
        end else if (clk_en) begin
            edge_r <= 1'b0;
            if (!active || sample_in == level_r) begin
                cnt_r <= '0;
            end else if (cnt_r >= limit) begin
                cnt_r <= '0;
                level_r <= sample_in;
                edge_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign level_out = level_r;
    assign edge_out = edge_r;

    // written on the update condition so a frozen clk_en cannot fake a stale edge
    property p_edge_after_filter;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && active && sample_in != level_r && cnt_r >= limit)
            |=> (edge_r && level_r == $past(sample_in));
    endproperty
    a_edge_after_filter: assert property (p_edge_after_filter)
        else $error("filter edge without level change");

    property p_filter_restart;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && (!active || sample_in == level_r)) |=> (!edge_r && cnt_r == '0);
    endproperty
    a_filter_restart: assert property (p_filter_restart)
        else $error("filter did not restart");
endmodule : wkd_filter

/* hw/wkd_top.sv */
// wake input detector: three wake pins plus two fail-safe alternates
// assumes raw pins asynchronous; cyclic windows come from on-chip timers
`timescale 1ns/1ps
`include "wkd_map.svh"
// Summary of operation
// - every wake input detects both rising and falling edges.
// - wake event raises interrupt in normal/stop, wake-up in sleep/fail-safe.
// - static sense monitors always; cyclic sense only inside timer window.
// - cyclic pins take their window from timer a or timer b.
// - static sense filter is selectable 16 or 64 microseconds.
// - filter starts at crossing; wake accepted if no crossing back.
// - per-pin wake enable; disabled pins cause no wake.
// - per-pin sticky wake source flags for the three inputs.
// - live pin level readable in normal and stop modes.
// - cyclic sense reports level captured at last window.
// - fail-safe alternates use fixed 16 us filter, separate flags.
// - configurable pull-up and pull-down per input.
// - bias select 00 none, 01 down, 10 up, 11 automatic.
// - detect select 00/01 static 16/64, 10/11 cyclic a/b.
module wkd_top
    import wkd_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [`WKD_NUM_WAKE-1:0] wake_pin_n,
    input wire logic [`WKD_NUM_ALT-1:0] alt_pin,
    input wire logic [`WKD_NUM_ALT-1:0] alt_wake_cfg,
    input wire wkd_mode_type op_mode,
    input wire wkd_pin_cfg_type [`WKD_NUM_WAKE-1:0] pin_cfg,
    input wire logic cyclic_timer_a,
    input wire logic cyclic_timer_b,
    input wire logic [`WKD_NUM_WAKE-1:0] wake_flag_clr,
    input wire logic [`WKD_NUM_ALT-1:0] alt_flag_clr,
    output logic [`WKD_NUM_WAKE-1:0] wake_source_flags,
    output logic [`WKD_NUM_ALT-1:0] alternate_wake_flags,
    output logic [`WKD_NUM_WAKE-1:0] wake_level_status,
    output wkd_bias_type [`WKD_NUM_WAKE-1:0] bias_out,
    output logic irq_out,
    output logic wakeup_out
);
    logic [`WKD_NUM_WAKE-1:0] sync1_r;
    logic [`WKD_NUM_WAKE-1:0] sync2_r;
    logic [`WKD_NUM_ALT-1:0] async1_r;
    logic [`WKD_NUM_ALT-1:0] async2_r;
    logic [`WKD_NUM_WAKE-1:0] filt_level;
    logic [`WKD_NUM_WAKE-1:0] filt_edge;
    logic [`WKD_NUM_WAKE-1:0] win_active;
    logic [`WKD_NUM_WAKE-1:0] is_cyclic;
    logic [`WKD_NUM_WAKE-1:0] sampled_r;
    logic [`WKD_NUM_ALT-1:0] alt_edge;
    logic [`WKD_NUM_WAKE-1:0] flags_r;
    logic [`WKD_NUM_WAKE-1:0] flags_nxt;
    logic [`WKD_NUM_ALT-1:0] alt_flags_r;
    logic [`WKD_NUM_ALT-1:0] alt_flags_nxt;
    logic [`WKD_NUM_WAKE-1:0] level_r;
    wkd_bias_type [`WKD_NUM_WAKE-1:0] bias_r;
    logic irq_r;
    logic wakeup_r;
    logic low_power;
    logic any_event;
    logic [`WKD_NUM_WAKE-1:0] wake_en_vec;

    function automatic logic det_cyclic(input logic [1:0] sel);
        det_cyclic = (sel == `WKD_DET_CYCLIC_A) || (sel == `WKD_DET_CYCLIC_B);
    endfunction : det_cyclic

    function automatic logic det_window(input logic [1:0] sel,
                                        input logic ta, input logic tb);
        case (sel)
            `WKD_DET_CYCLIC_A: det_window = ta;
            `WKD_DET_CYCLIC_B: det_window = tb;
            default: det_window = 1'b1;
        endcase
    endfunction : det_window

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            async1_r <= '0;
            async2_r <= '0;
        end else if (clk_en) begin
            sync1_r <= wake_pin_n;
            sync2_r <= sync1_r;
            async1_r <= alt_pin;
            async2_r <= async1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // filters
    genvar gi;
    generate
        for (gi = 0; gi < `WKD_NUM_WAKE; gi++) begin : g_wake
            assign is_cyclic[gi] = det_cyclic(pin_cfg[gi].detect_sel);
            assign wake_en_vec[gi] = pin_cfg[gi].wake_en;
            assign win_active[gi] = det_window(pin_cfg[gi].detect_sel,
                                               cyclic_timer_a, cyclic_timer_b);
            // only long in static config b; cyclic always short
            wkd_filter u_filt (
                .core_clk(core_clk),
                .nrst(nrst),
                .clk_en(clk_en),
                .sample_in(sync2_r[gi]),
                .active(win_active[gi]),
                .long_sel(pin_cfg[gi].detect_sel == `WKD_DET_STATIC_LONG),
                .level_out(filt_level[gi]),
                .edge_out(filt_edge[gi])
            );
        end
        for (gi = 0; gi < `WKD_NUM_ALT; gi++) begin : g_alt
            wkd_filter u_alt_filt (
                .core_clk(core_clk),
                .nrst(nrst),
                .clk_en(clk_en),
                .sample_in(async2_r[gi]),
                .active(alt_wake_cfg[gi]),
                .long_sel(1'b0),
                .level_out(),
                .edge_out(alt_edge[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // sticky flags: set wins over clear
    always_comb begin
        flags_nxt = (flags_r & ~wake_flag_clr) | (filt_edge & wake_en_vec);
        alt_flags_nxt = (alt_flags_r & ~alt_flag_clr) | (alt_edge & alt_wake_cfg);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flags_r <= '0;
            alt_flags_r <= '0;
        end else if (clk_en) begin
            flags_r <= flags_nxt;
            alt_flags_r <= alt_flags_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // level readback: live in static, last window sample in cyclic
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sampled_r <= '0;
            level_r <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < `WKD_NUM_WAKE; i++) begin
                // static pins count as always sampling, so cyclic starts from a real level
                if (win_active[i]) begin
                    sampled_r[i] <= sync2_r[i];
                end
                if (!low_power) begin
                    level_r[i] <= is_cyclic[i] ? sampled_r[i] : sync2_r[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bias sources; automatic follows filtered level
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bias_r <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < `WKD_NUM_WAKE; i++) begin
                case (pin_cfg[i].bias_sel)
                    `WKD_BIAS_DOWN: bias_r[i] <= 2'b01;
                    `WKD_BIAS_UP: bias_r[i] <= 2'b10;
                    `WKD_BIAS_AUTO: bias_r[i] <= filt_level[i] ? 2'b10 : 2'b01;
                    default: bias_r[i] <= 2'b00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // signalling by mode
    assign low_power = (op_mode == WKD_SLEEP) || (op_mode == WKD_FAILSAFE);
    assign any_event = (|(filt_edge & wake_en_vec)) || (|(alt_edge & alt_wake_cfg));

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_r <= 1'b0;
            wakeup_r <= 1'b0;
        end else if (clk_en) begin
            irq_r <= any_event && !low_power;
            wakeup_r <= any_event && low_power;
        end
    end

    assign wake_source_flags = flags_r;
    assign alternate_wake_flags = alt_flags_r;
    assign wake_level_status = level_r;
    assign bias_out = bias_r;
    assign irq_out = irq_r;
    assign wakeup_out = wakeup_r;

    ////////////////////////////////////////////////////////////////////////
    property p_flag_set;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && filt_edge[0] && pin_cfg[0].wake_en) |=> flags_r[0];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("wake flag not set");

    property p_flag_sticky;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && flags_r[1] && !wake_flag_clr[1]) |=> flags_r[1];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("wake flag lost");

    property p_disabled_no_flag;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && !pin_cfg[2].wake_en && !flags_r[2]) |=> !flags_r[2];
    endproperty
    a_disabled_no_flag: assert property (p_disabled_no_flag)
        else $error("disabled pin set flag");

    property p_irq_mode;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && low_power) |=> !irq_r;
    endproperty
    a_irq_mode: assert property (p_irq_mode)
        else $error("irq in low power mode");

    property p_wake_mode;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && any_event && low_power) |=> wakeup_r;
    endproperty
    a_wake_mode: assert property (p_wake_mode)
        else $error("missing wake-up");

    property p_bias_down;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && pin_cfg[0].bias_sel == `WKD_BIAS_DOWN) |=> bias_r[0] == 2'b01;
    endproperty
    a_bias_down: assert property (p_bias_down)
        else $error("bias decode wrong");

    property p_alt_flag;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && alt_edge[0] && alt_wake_cfg[0]) |=> alternate_wake_flags[0];
    endproperty
    a_alt_flag: assert property (p_alt_flag)
        else $error("alternate flag missing");

    property p_static_level;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && !is_cyclic[0] && !low_power) |=> level_r[0] == $past(sync2_r[0]);
    endproperty
    a_static_level: assert property (p_static_level)
        else $error("level status wrong");

    c_irq: cover property (@(posedge core_clk) irq_r);
    c_wake: cover property (@(posedge core_clk) wakeup_r);
    c_alt: cover property (@(posedge core_clk) |alt_flags_r);
endmodule : wkd_top

/* bench/wkd_pin_model.sv */
// behavioural switches and sensors on the wake and alternate pins
// assumes the bench asks for a level and, for chatter, an inverted level
`timescale 1ns/1ps
module wkd_pin_model (
    input wire logic [4:0] level,
    input wire logic [4:0] chatter,
    output logic [2:0] wake_pin_n,
    output logic [1:0] alt_pin
);
    // contacts move off the clock edge: the pins are asynchronous
    assign #3 {alt_pin, wake_pin_n} = level ^ chatter;
endmodule : wkd_pin_model

/* bench/tb_wake_input_detect.sv */
// self-checking bench for the wake input detector
// assumes filter counts of 1600 and 6400 cycles at 100 MHz
`timescale 1ns/1ps
`include "wkd_map.svh"
module tb_wake_input_detect
    import wkd_pkg::*;
;
logic core_clk = 1'b0;
logic nrst = 1'b0;
logic ce = 1'b1;
logic [4:0] tgt = 5'h00;
logic [4:0] glt = 5'h00;
logic [2:0] wake_pin_n;
logic [1:0] alt_pin;
logic [1:0] alt_wake_cfg = 2'h0;
wkd_mode_type op_mode = WKD_NORMAL;
wkd_pin_cfg_type [2:0] pin_cfg = '0;
logic cyc_a = 1'b0;
logic cyc_b = 1'b0;
logic [2:0] wclr = 3'h0;
logic [1:0] aclr = 2'h0;
logic [2:0] wflags;
logic [2:0] lvl;
logic [1:0] aflags;
wkd_bias_type [2:0] bias;
logic irq;
logic wk;
logic seen_irq = 1'b0;
logic seen_wk = 1'b0;
int failures = 0;
int n_checks = 0;
////////////////////////////////////////////////////////////////////////////////
wkd_pin_model wkd_pin_model_inst (.level(tgt), .chatter(glt), .wake_pin_n(wake_pin_n),
    .alt_pin(alt_pin));
wkd_top wkd_top_inst (.core_clk(core_clk), .nrst(nrst), .clk_en(ce),
    .wake_pin_n(wake_pin_n), .alt_pin(alt_pin), .alt_wake_cfg(alt_wake_cfg),
    .op_mode(op_mode), .pin_cfg(pin_cfg), .cyclic_timer_a(cyc_a), .cyclic_timer_b(cyc_b),
    .wake_flag_clr(wclr), .alt_flag_clr(aclr), .wake_source_flags(wflags),
    .alternate_wake_flags(aflags), .wake_level_status(lvl), .bias_out(bias),
    .irq_out(irq), .wakeup_out(wk));
////////////////////////////////////////////////////////////////////////////////
task automatic report_and_stop;
    if (failures == 0 && n_checks > 0) begin
        $display("TB: PASS");
    end else begin
        $display("TB: FAIL");
    end
    $finish;
endtask : report_and_stop

task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
        failures++;
        $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
endtask : chk

function automatic logic [1:0] exp_bias(input int b, input logic up);
    case (b)
        0: return 2'h0;
        1: return 2'h1;
        2: return 2'h2;
        default: return up ? 2'h2 : 2'h1;
    endcase
endfunction : exp_bias

// inputs move only on the falling edge; irq and wakeup are single pulses
task automatic step(input int n);
    repeat (n) begin
        @(negedge core_clk);
        seen_irq |= irq;
        seen_wk |= wk;
    end
endtask : step

task automatic clr_all;
    wclr = 3'h7;
    aclr = 2'h3;
    step(1);
    wclr = 3'h0;
    aclr = 2'h0;
    step(3);
    seen_irq = 1'b0;
    seen_wk = 1'b0;
    chk("flags cleared", 8'h00, {3'h0, aflags, wflags});
endtask : clr_all

// flag must stay low just short of the filter and equal hit just after it
task automatic ev(input int i, input int n, input logic flip, input logic hit);
    logic [4:0] f;
    tgt[i] = tgt[i] ^ flip;
    step(n - 6);
    f = {aflags, wflags};
    chk("flag early", 8'h00, {7'h0, f[i]});
    step(16);
    f = {aflags, wflags};
    chk("flag", {7'h0, hit}, {7'h0, f[i]});
endtask : ev

task automatic setc(input int p, input logic [1:0] d, input logic e);
    pin_cfg[p].detect_sel = d;
    pin_cfg[p].wake_en = e;
endtask : setc
////////////////////////////////////////////////////////////////////////////////
initial begin
    forever #5 core_clk = ~core_clk;
end

// hang guard: far beyond the longest sequence
initial begin
    #900000;
    failures++;
    report_and_stop();
end

initial begin
    int g;
    void'($urandom(32'hc61d3d57));
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    step(1);
    chk("reset outputs", 8'h00, {wflags, aflags, irq, wk, 1'b0});
    // pins are low, so automatic bias must pick the pull-down
    for (int b = 0; b < 4; b++) begin
        foreach (pin_cfg[p]) pin_cfg[p].bias_sel = 2'(b);
        step(3);
        chk("bias", {2'h0, {3{exp_bias(b, 1'b0)}}}, {2'h0, bias});
    end
    setc(0, `WKD_DET_STATIC_SHORT, 1'b1);
    setc(1, `WKD_DET_STATIC_LONG, 1'b1);
    setc(2, `WKD_DET_STATIC_SHORT, 1'b0);
    ev(0, 1600, 1'b1, 1'b1);
    chk("irq in normal", 8'h01, {6'h0, seen_wk, seen_irq});
    chk("auto bias up", {6'h0, exp_bias(3, 1'b1)}, {6'h0, bias[0]});
    chk("level live", {5'h0, tgt[2:0]}, {5'h0, lvl});
    clr_all();
    repeat (3) begin
        g = 100 + int'($urandom % 1400);
        glt[0] = 1'b1;
        step(g);
        glt[0] = 1'b0;
        step(1700);
        chk("glitch rejected", 8'h00, {4'h0, seen_irq, wflags});
    end
    // clock enable low freezes synchronisers and filters
    ce = 1'b0;
    tgt[0] = ~tgt[0];
    step(2000);
    chk("frozen", 8'h00, {4'h0, seen_irq, wflags});
    ce = 1'b1;
    ev(0, 1600, 1'b0, 1'b1);
    // rising edge in normal and sleep, falling edge in stop and fail-safe; pin ends at its starting level
    for (int m = 0; m < 4; m++) begin
        op_mode = wkd_mode_type'(m);
        clr_all();
        ev(0, 1600, 1'b1, 1'b1);
        chk("signal kind", {6'h0, m > 1, m < 2}, {6'h0, seen_wk, seen_irq});
    end
    op_mode = WKD_NORMAL;
    clr_all();
    ev(1, 6400, 1'b1, 1'b1);
    clr_all();
    ev(2, 1600, 1'b1, 1'b0);
    chk("disabled no irq", 8'h00, {7'h0, seen_irq});
    chk("level disabled pin", {5'h0, tgt[2:0]}, {5'h0, lvl});
    // the other timer's window is open while the pin moves
    for (int t = 0; t < 2; t++) begin
        setc(2, t ? `WKD_DET_CYCLIC_B : `WKD_DET_CYCLIC_A, 1'b1);
        clr_all();
        cyc_a = (t == 1);
        cyc_b = (t == 0);
        tgt[2] = ~tgt[2];
        step(2000);
        chk("window closed", {6'h0, 1'b0, ~tgt[2]}, {6'h0, wflags[2], lvl[2]});
        cyc_a = (t == 0);
        cyc_b = (t == 1);
        ev(2, 1600, 1'b0, 1'b1);
        chk("sampled level", {7'h0, tgt[2]}, {7'h0, lvl[2]});
        cyc_a = 1'b0;
        cyc_b = 1'b0;
    end
    alt_wake_cfg = 2'h3;
    clr_all();
    ev(3, 1600, 1'b1, 1'b1);
    ev(4, 1600, 1'b1, 1'b1);
    chk("alt kept apart", 8'h00, {5'h0, wflags});
    chk("alt irq", 8'h01, {6'h0, seen_wk, seen_irq});
    report_and_stop();
end
endmodule : tb_wake_input_detect
